// *** src/ccr_pkg.sv ***
// constants for the core configuration register
package ccr_pkg;
   localparam int CCR_WIDTH = 32;
   localparam int CCR_M_POS = 31;
   localparam int CCR_K23_LSB = 28;
   localparam int CCR_KU_LSB = 25;
   localparam int CCR_MDU_POS = 20;
   localparam int CCR_MM_LSB = 17;
   localparam int CCR_BM_POS = 16;
   localparam int CCR_BE_POS = 15;
   localparam int CCR_AT_LSB = 13;
   localparam int CCR_AR_LSB = 10;
   localparam int CCR_MT_LSB = 7;
   localparam int CCR_K0_LSB = 0;
   localparam logic [2:0] CCR_ATTR_RESET = 3'h2;
   localparam logic [1:0] CCR_SYNC_FILL = 2'h3;
   localparam logic [1:0] CCR_AT_VALUE = 2'h0;
   localparam logic [2:0] CCR_AR_VALUE = 3'h0;
   localparam logic [2:0] CCR_MT_TLB = 3'h1;
   localparam logic [2:0] CCR_MT_FIXED = 3'h3;
   localparam logic [2:0] CCR_ATTR_CACHED = 3'h3;
   localparam logic [2:0] CCR_ATTR_UNCACHED = 3'h2;
   localparam logic [31:0] CCR_WRITE_MASK_FM = 32'h7E00_0007;
   localparam logic [31:0] CCR_WRITE_MASK_TLB = 32'h0000_0007;
endpackage : ccr_pkg

// *** src/ccr_core_config.sv ***
// core configuration register with coherency attribute decode
// Operation
// - bit 31 always reads one
// - upper kernel attr writable only fixed mapping
// - user attr writable only fixed mapping
// - reserved bits read zero, written zero
// - bit 20 reports multiplier type preset
// - bits 18:17 report write buffer merge
// - bit 15 endian, bit 16 burst order
// - architecture type reads 00
// - architecture revision reads 000
// - bits 9:7 report memory management type
// - kernel cached attr writable, resets 010
// - codes 2,7 uncached, others cached
// - unused codes alias to 3 or 2
`timescale 1ns/10ps
module ccr_core_config
   import ccr_pkg::*;
#(
   parameter bit fixed_mapping = 1'b1,
   parameter bit multiplier_type = 1'b0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [ccr_pkg::CCR_WIDTH-1:0] wr_data,
   input wire logic [1:0] write_buffer_merge_mode_in,
   input wire logic burst_order_in,
   input wire logic big_endian_flag_in,
   output logic [ccr_pkg::CCR_WIDTH-1:0] rd_data,
   output logic [2:0] cached_kernel_seg_attr_eff,
   output logic cached_kernel_seg_uncached,
   output logic [2:0] upper_kernel_seg_attr_eff,
   output logic upper_kernel_seg_uncached,
   output logic [2:0] user_seg_attr_eff,
   output logic user_seg_uncached
);
   import ccr_pkg::*;

   function automatic logic [2:0] attr_alias(input logic [2:0] c);
      attr_alias = (c == 3'h2 || c == 3'h7) ? CCR_ATTR_UNCACHED : CCR_ATTR_CACHED;
   endfunction : attr_alias

   function automatic logic attr_unc(input logic [2:0] c);
      attr_unc = (attr_alias(c) == CCR_ATTR_UNCACHED);
   endfunction : attr_unc

   logic [2:0] k0_reg, k0_next, k23_reg, k23_next, ku_reg, ku_next;
   logic [1:0] mm_s1_reg, mm_s2_reg, mm_s3_reg, mm_reg, mm_next;
   logic [1:0] bb_s1_reg, bb_s2_reg, bb_s3_reg;
   logic [1:0] fill_reg, fill_next;
   logic bm_reg, bm_next, be_reg, be_next;
   logic cap_reg, cap_next;
   logic [31:0] rd_next, wmask;
   logic [2:0] k0e_next, k23e_next, kue_next;

   // register image while reset is held
   localparam logic [31:0] RESET_IMAGE = {1'b1,
      (fixed_mapping ? {CCR_ATTR_RESET, CCR_ATTR_RESET} : 6'h00), 4'h0, multiplier_type,
      1'b0, 2'h0, 1'b0, 1'b0, CCR_AT_VALUE, CCR_AR_VALUE,
      (fixed_mapping ? CCR_MT_FIXED : CCR_MT_TLB), 4'h0, CCR_ATTR_RESET};

   always_comb begin
      wmask = fixed_mapping ? CCR_WRITE_MASK_FM : CCR_WRITE_MASK_TLB;
      k0_next = k0_reg;
      k23_next = k23_reg;
      ku_next = ku_reg;
      if (wr_en) begin
         k0_next = wr_data[CCR_K0_LSB +: 3];
         if (wmask[CCR_K23_LSB]) begin
            k23_next = wr_data[CCR_K23_LSB +: 3];
            ku_next = wr_data[CCR_KU_LSB +: 3];
         end
      end
      // count edges until the sync chain holds real samples
      fill_next = (fill_reg == CCR_SYNC_FILL) ? fill_reg : fill_reg + 2'h1;
      // capture straps once synchronised, then hold
      cap_next = 1'b1;
      mm_next = mm_reg;
      bm_next = bm_reg;
      be_next = be_reg;
      if (!cap_reg && fill_reg == CCR_SYNC_FILL &&
            mm_s2_reg == mm_s3_reg && bb_s2_reg == bb_s3_reg) begin
         mm_next = mm_s3_reg;
         bm_next = bb_s3_reg[1];
         be_next = bb_s3_reg[0];
      end else if (!cap_reg) begin
         cap_next = 1'b0;
      end
      rd_next = 32'h0000_0000;
      rd_next[CCR_M_POS] = 1'b1;
      rd_next[CCR_K23_LSB +: 3] = fixed_mapping ? k23_next : 3'h0;
      rd_next[CCR_KU_LSB +: 3] = fixed_mapping ? ku_next : 3'h0;
      rd_next[CCR_MDU_POS] = multiplier_type;
      rd_next[CCR_MM_LSB +: 2] = mm_next;
      rd_next[CCR_BM_POS] = bm_next;
      rd_next[CCR_BE_POS] = be_next;
      rd_next[CCR_AT_LSB +: 2] = CCR_AT_VALUE;
      rd_next[CCR_AR_LSB +: 3] = CCR_AR_VALUE;
      rd_next[CCR_MT_LSB +: 3] = fixed_mapping ? CCR_MT_FIXED : CCR_MT_TLB;
      rd_next[CCR_K0_LSB +: 3] = k0_next;
      k0e_next = attr_alias(k0_next);
      k23e_next = attr_alias(fixed_mapping ? k23_next : CCR_ATTR_RESET);
      kue_next = attr_alias(fixed_mapping ? ku_next : CCR_ATTR_RESET);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         k0_reg <= CCR_ATTR_RESET;
         k23_reg <= fixed_mapping ? CCR_ATTR_RESET : 3'h0;
         ku_reg <= fixed_mapping ? CCR_ATTR_RESET : 3'h0;
         mm_s1_reg <= 2'h0;
         mm_s2_reg <= 2'h0;
         mm_s3_reg <= 2'h0;
         bb_s1_reg <= 2'h0;
         bb_s2_reg <= 2'h0;
         bb_s3_reg <= 2'h0;
         fill_reg <= 2'h0;
         mm_reg <= 2'h0;
         bm_reg <= 1'b0;
         be_reg <= 1'b0;
         cap_reg <= 1'b0;
         rd_data <= RESET_IMAGE;
         cached_kernel_seg_attr_eff <= CCR_ATTR_UNCACHED;
         cached_kernel_seg_uncached <= 1'b1;
         upper_kernel_seg_attr_eff <= CCR_ATTR_UNCACHED;
         upper_kernel_seg_uncached <= 1'b1;
         user_seg_attr_eff <= CCR_ATTR_UNCACHED;
         user_seg_uncached <= 1'b1;
      end else begin
         k0_reg <= k0_next;
         k23_reg <= k23_next;
         ku_reg <= ku_next;
         mm_s1_reg <= write_buffer_merge_mode_in;
         mm_s2_reg <= mm_s1_reg;
         mm_s3_reg <= mm_s2_reg;
         bb_s1_reg <= {burst_order_in, big_endian_flag_in};
         bb_s2_reg <= bb_s1_reg;
         bb_s3_reg <= bb_s2_reg;
         fill_reg <= fill_next;
         mm_reg <= mm_next;
         bm_reg <= bm_next;
         be_reg <= be_next;
         cap_reg <= cap_next;
         rd_data <= rd_next;
         cached_kernel_seg_attr_eff <= k0e_next;
         cached_kernel_seg_uncached <= attr_unc(k0e_next);
         upper_kernel_seg_attr_eff <= k23e_next;
         upper_kernel_seg_uncached <= attr_unc(k23e_next);
         user_seg_attr_eff <= kue_next;
         user_seg_uncached <= attr_unc(kue_next);
      end
   end

   property p_msb_one;
      @(posedge clk) disable iff (!rstn) 1'b1 |=> rd_data[CCR_M_POS];
   endproperty
   a_msb_one: assert property (p_msb_one) else $error("bit 31 not one");

   property p_k23;
      @(posedge clk) disable iff (!rstn)
         wr_en |=> rd_data[CCR_K23_LSB +: 3] ==
            (fixed_mapping ? $past(wr_data[CCR_K23_LSB +: 3]) : 3'h0);
   endproperty
   a_k23: assert property (p_k23) else $error("upper kernel attr wrong");

   property p_ku;
      @(posedge clk) disable iff (!rstn)
         wr_en ##1 !wr_en |=> rd_data[CCR_KU_LSB +: 3] ==
            (fixed_mapping ? $past(wr_data[CCR_KU_LSB +: 3], 2) : 3'h0);
   endproperty
   a_ku: assert property (p_ku) else $error("user attr wrong");

   property p_resv;
      @(posedge clk) disable iff (!rstn)
         rd_data[24:21] == 4'h0 && !rd_data[19] && rd_data[6:3] == 4'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");

   property p_mdu;
      @(posedge clk) disable iff (!rstn) ##1 rd_data[CCR_MDU_POS] == multiplier_type;
   endproperty
   a_mdu: assert property (p_mdu) else $error("multiplier bit wrong");

   property p_straps_hold;
      @(posedge clk) disable iff (!rstn)
         cap_reg |=> $stable(rd_data[CCR_MM_LSB +: 2]) && $stable(rd_data[16:15]);
   endproperty
   a_straps_hold: assert property (p_straps_hold) else $error("strap changed");

   property p_arch;
      @(posedge clk) disable iff (!rstn)
         ##1 rd_data[14:10] == 5'h00 &&
            rd_data[CCR_MT_LSB +: 3] == (fixed_mapping ? 3'h3 : 3'h1);
   endproperty
   a_arch: assert property (p_arch) else $error("fixed fields wrong");

   property p_k0;
      @(posedge clk) disable iff (!rstn)
         wr_en |=> rd_data[2:0] == $past(wr_data[2:0]) &&
            cached_kernel_seg_uncached ==
            ($past(wr_data[2:0]) == 3'h2 || $past(wr_data[2:0]) == 3'h7);
   endproperty
   a_k0: assert property (p_k0) else $error("kernel attr decode wrong");

   property p_strap_capture;
      @(posedge clk) disable iff (!rstn)
         $rose(cap_reg) |-> rd_data[CCR_MM_LSB +: 2] == $past(mm_s3_reg) &&
            rd_data[CCR_BM_POS] == $past(bb_s3_reg[1]) &&
            rd_data[CCR_BE_POS] == $past(bb_s3_reg[0]);
   endproperty
   a_strap_capture: assert property (p_strap_capture) else $error("strap capture wrong");

   property p_k0_reset;
      @(posedge clk) disable iff (!rstn)
         $rose(rstn) |-> rd_data[CCR_K0_LSB +: 3] == CCR_ATTR_RESET && cached_kernel_seg_uncached;
   endproperty
   a_k0_reset: assert property (p_k0_reset) else $error("kernel attr reset wrong");

   property p_k0_alias;
      @(posedge clk) disable iff (!rstn)
         cached_kernel_seg_attr_eff ==
            ((rd_data[2:0] == 3'h2 || rd_data[2:0] == 3'h7) ? 3'h2 : 3'h3);
   endproperty
   a_k0_alias: assert property (p_k0_alias) else $error("kernel attr alias wrong");

   property p_upper_alias;
      @(posedge clk) disable iff (!rstn)
         fixed_mapping |-> upper_kernel_seg_uncached ==
            (rd_data[CCR_K23_LSB +: 3] == 3'h2 || rd_data[CCR_K23_LSB +: 3] == 3'h7);
   endproperty
   a_upper_alias: assert property (p_upper_alias) else $error("upper attr flag wrong");

   property p_user_alias;
      @(posedge clk) disable iff (!rstn)
         fixed_mapping |-> user_seg_uncached ==
            (rd_data[CCR_KU_LSB +: 3] == 3'h2 || rd_data[CCR_KU_LSB +: 3] == 3'h7);
   endproperty
   a_user_alias: assert property (p_user_alias) else $error("user attr flag wrong");

   property p_tlb_attr;
      @(posedge clk) disable iff (!rstn)
         !fixed_mapping |-> upper_kernel_seg_uncached && user_seg_uncached;
   endproperty
   a_tlb_attr: assert property (p_tlb_attr) else $error("mapped attr not uncached");
endmodule : ccr_core_config

// *** testbench/ccr_core_config_tb_top.sv ***
// self-checking bench for the core configuration register
`timescale 1ns/10ps
module ccr_core_config_tb_top;
   import ccr_pkg::*;
   logic clk, rstn, wr_en, bo_in, be_in, sbo, sbe;
   logic [1:0] mm_in, smm;
   logic [31:0] wr_data, rd_f, rd_t;
   logic [2:0] k0_f, k23_f, ku_f, k0_t, k23_t, ku_t, sk0, sk23, sku;
   logic u0_f, u23_f, uu_f, u0_t, u23_t, uu_t;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   ccr_core_config #(.fixed_mapping(1'b1), .multiplier_type(1'b1)) ccr_core_config_inst (
      .clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_data(wr_data),
      .write_buffer_merge_mode_in(mm_in), .burst_order_in(bo_in), .big_endian_flag_in(be_in),
      .rd_data(rd_f), .cached_kernel_seg_attr_eff(k0_f), .cached_kernel_seg_uncached(u0_f),
      .upper_kernel_seg_attr_eff(k23_f), .upper_kernel_seg_uncached(u23_f),
      .user_seg_attr_eff(ku_f), .user_seg_uncached(uu_f));
   ccr_core_config #(.fixed_mapping(1'b0), .multiplier_type(1'b0)) ccr_core_config_tlb_inst (
      .clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_data(wr_data),
      .write_buffer_merge_mode_in(mm_in), .burst_order_in(bo_in), .big_endian_flag_in(be_in),
      .rd_data(rd_t), .cached_kernel_seg_attr_eff(k0_t), .cached_kernel_seg_uncached(u0_t),
      .upper_kernel_seg_attr_eff(k23_t), .upper_kernel_seg_uncached(u23_t),
      .user_seg_attr_eff(ku_t), .user_seg_uncached(uu_t));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] exp_rd(input bit fm, input bit mul);
      exp_rd = {1'b1, fm ? {sk23, sku} : 6'h00, 4'h0, mul, 1'b0, smm, sbo, sbe, 2'h0, 3'h0,
         fm ? 3'h3 : 3'h1, 4'h0, sk0};
   endfunction : exp_rd
   // aliased code and uncached flag
   function automatic logic [3:0] att(input logic [2:0] c);
      att = (c == 3'h2 || c == 3'h7) ? 4'h5 : 4'h6;
   endfunction : att
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task check_all;
      chk(rd_f, exp_rd(1'b1, 1'b1));
      chk(rd_t, exp_rd(1'b0, 1'b0));
      chk({20'h0, k0_f, u0_f, k23_f, u23_f, ku_f, uu_f}, {20'h0, att(sk0), att(sk23), att(sku)});
      chk({20'h0, k0_t, u0_t, k23_t, u23_t, ku_t, uu_t}, {20'h0, att(sk0), 8'h55});
   endtask : check_all
   task wr(input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_data <= d;
      sk0 = d[2:0];
      sk23 = d[30:28];
      sku = d[27:25];
   endtask : wr
   task settle;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
      #1 check_all;
   endtask : settle
   task rst;
      @(posedge clk);
      smm = 2'($urandom);
      sbo = 1'($urandom);
      sbe = 1'($urandom);
      rstn <= 1'b0;
      mm_in <= smm;
      bo_in <= sbo;
      be_in <= sbe;
      sk0 = 3'h2;
      sk23 = 3'h2;
      sku = 3'h2;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      #1 check_all;
   endtask : rst
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         give_verdict;
      end
   end
   initial begin
      rstn = 1'b0;
      wr_en = 1'b0;
      wr_data = 32'h0000_0000;
      {mm_in, bo_in, be_in} = 4'h0;
      void'($urandom(32'h94b6_152a));
      rst;
      for (int i = 0; i < 8; i++) begin
         wr({1'b0, 3'(i), 3'(i), 22'h0, 3'(i)});
         settle;
      end
      wr(32'hffff_ffff);
      wr(32'h0000_0000);
      wr(32'h8000_0005);
      settle;
      for (int i = 0; i < 40; i++) begin
         wr($urandom);
         if (i % 3 == 0) settle;
      end
      settle;
      // straps move after capture, register must not follow
      @(posedge clk);
      mm_in <= ~smm;
      bo_in <= ~sbo;
      be_in <= ~sbe;
      wr(32'h7e00_0007);
      repeat (3) settle;
      rst;
      for (int i = 0; i < 8; i++) begin
         wr($urandom);
         settle;
      end
      give_verdict;
   end
endmodule : ccr_core_config_tb_top
